// ==== core/granularity_tick.v ====
// Granularity tick generator for the idle timer.
// Assumes the clock is the PCI clock; periods are fixed clock counts.
`timescale 1ns/1ps
`default_nettype none

module granularity_tick #(
  parameter [31:0] MSEC_CYCLES   = 32'd33000,
  parameter [31:0] MINUTE_CYCLES = 32'd1980000000
) (
  // Clock and reset
  input  wire        clock,
  input  wire        rst_n,
  // Granularity select
  input  wire [1:0]  gran_sel,
  // One-cycle tick
  output reg         tick_r
);

  reg  [31:0] count_r;
  reg  [31:0] period;

  always @* begin
    case (gran_sel)
      2'h0:    period = MINUTE_CYCLES;
      2'h3:    period = MSEC_CYCLES;
      default: period = 32'h00000001;
    endcase
  end

  // Count restarts on a select change only through the disabled or per-clock code;
  // a live change between granularities ends once the count reaches or passes the new terminal value.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= 32'h00000000;
      tick_r  <= 1'b0;
    end else if (gran_sel == 2'h1) begin
      count_r <= 32'h00000000;
      tick_r  <= 1'b0;
    end else if (gran_sel == 2'h2) begin
      count_r <= 32'h00000000;
      tick_r  <= 1'b1;
    end else if (count_r >= period - 32'h00000001) begin
      count_r <= 32'h00000000;
      tick_r  <= 1'b1;
    end else begin
      count_r <= count_r + 32'h00000001;
      tick_r  <= 1'b0;
    end
  end

endmodule // granularity_tick

`default_nettype wire

// ==== core/mgmt_interrupt_gate_enable.v ====
// Management interrupt control, source enables, request status, idle timer
// and stop-clock output for a PCI-to-ISA bridge.
// Assumes byte-wide config accesses, one-cycle strobes, and inputs already
// synchronous to the PCI clock.
`timescale 1ns/1ps
`default_nettype none
`include "mgmt_irq_map.vh"

module mgmt_interrupt_gate_enable #(
  parameter [31:0] MSEC_CYCLES   = `TICK_MSEC_CYCLES,
  parameter [31:0] MINUTE_CYCLES = `TICK_MINUTE_CYCLES
) (
  // Clock and reset
  input  wire        clock,
  input  wire        rst_n,
  // Configuration port
  input  wire [7:0]  cfg_addr,
  input  wire [7:0]  cfg_wdata,
  input  wire        cfg_wr,
  input  wire        cfg_rd,
  output reg  [7:0]  cfg_rdata_r,
  // Power management command port strobes
  input  wire        cmd_port_wr,
  input  wire        cmd_port_rd,
  // Event sources
  input  wire        usb_legacy_req,
  input  wire        external_mgmt_request_n,
  input  wire [4:0]  irq_lines,
  // Stop-clock scaling times, in PCI clocks minus one
  input  wire [7:0]  scaling_high_time,
  input  wire [7:0]  scaling_low_time,
  // Outputs to the CPU
  output reg         mgmt_interrupt_out_n,
  output reg         stop_clock_out_n,
  // Status visibility
  output reg  [15:0] mgmt_request_status_r
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_LOW  = 2'h1;
  localparam [1:0] ST_HIGH = 2'h2;

  // Status bits that exist; the rest stay zero whatever is written
  localparam [15:0] SRC_LIVE = `SRC_MASK;

  reg  [7:0]  mgmt_irq_control_r;
  reg  [15:0] mgmt_irq_source_enable_r;
  reg  [7:0]  idle_timer_reload_r;
  reg  [8:0]  idle_count_r;
  reg         timer_expired_r;
  reg         ext_req_prev_r;
  reg         usb_prev_r;
  reg  [4:0]  irq_prev_r;
  reg  [1:0]  stop_state_r;
  reg  [1:0]  stop_state_nxt;
  reg  [7:0]  stop_count_r;
  reg  [7:0]  stop_count_nxt;
  wire [15:0] status_nxt;
  wire [15:0] status_set;
  wire [15:0] status_keep;
  reg  [15:0] event_raw;
  reg  [15:0] clear_mask;
  wire        wr_control;
  wire        wr_enable_lo;
  wire        wr_enable_hi;
  wire        wr_reload;
  wire        wr_status_lo;
  wire        wr_status_hi;
  wire        gran_tick;
  wire [1:0]  idle_timer_granularity_select;
  wire        gate_on;
  wire        stop_en;
  wire        stop_clock_scaling_enable;
  wire [8:0]  reload_plus_one;
  genvar      g;

  function cfg_hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      cfg_hit = (addr == ofs);
    end
  endfunction

  assign idle_timer_granularity_select =
    mgmt_irq_control_r[`CTL_GRAN_MSB:`CTL_GRAN_LSB];
  assign gate_on                   = mgmt_irq_control_r[`CTL_GATE];
  assign stop_en                   = mgmt_irq_control_r[`CTL_STOP_EN];
  assign stop_clock_scaling_enable = mgmt_irq_control_r[`CTL_SCALE_EN];
  assign reload_plus_one           = {1'b0, idle_timer_reload_r} + 9'h001;

  // Byte write decodes, shared by the registers and the status clear
  assign wr_control   = cfg_wr & cfg_hit(cfg_addr, `OFS_CONTROL);
  assign wr_enable_lo = cfg_wr & cfg_hit(cfg_addr, `OFS_ENABLE_LO);
  assign wr_enable_hi = cfg_wr & cfg_hit(cfg_addr, `OFS_ENABLE_HI);
  assign wr_reload    = cfg_wr & cfg_hit(cfg_addr, `OFS_TIMER_RELOAD);
  assign wr_status_lo = cfg_wr & cfg_hit(cfg_addr, `OFS_STATUS_LO);
  assign wr_status_hi = cfg_wr & cfg_hit(cfg_addr, `OFS_STATUS_HI);

  // Control register; reserved bits are never stored, so they read zero
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mgmt_irq_control_r <= `RST_CONTROL;
    end else if (wr_control) begin
      mgmt_irq_control_r <= cfg_wdata & `CTL_MASK;
    end
  end

  // Source enables; of the high byte only bit 8 is implemented
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mgmt_irq_source_enable_r <= `RST_ENABLE;
    end else begin
      if (wr_enable_lo)
        mgmt_irq_source_enable_r[7:0] <= cfg_wdata;
      if (wr_enable_hi)
        mgmt_irq_source_enable_r[15:8] <= cfg_wdata & 8'h01;
    end
  end

  // Written value only takes effect at the next reload; stop the timer first
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      idle_timer_reload_r <= `RST_TIMER_RELOAD;
    end else if (wr_reload) begin
      idle_timer_reload_r <= cfg_wdata;
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rdata_r <= 8'h00;
    end else if (cfg_rd) begin
      case (cfg_addr)
        `OFS_CONTROL:      cfg_rdata_r <= mgmt_irq_control_r;
        `OFS_ENABLE_LO:    cfg_rdata_r <= mgmt_irq_source_enable_r[7:0];
        `OFS_ENABLE_HI:    cfg_rdata_r <= mgmt_irq_source_enable_r[15:8];
        `OFS_TIMER_RELOAD: cfg_rdata_r <= idle_timer_reload_r;
        `OFS_STATUS_LO:    cfg_rdata_r <= mgmt_request_status_r[7:0];
        `OFS_STATUS_HI:    cfg_rdata_r <= mgmt_request_status_r[15:8];
        default:           cfg_rdata_r <= 8'h00;
      endcase
    end
  end

  granularity_tick #(
    .MSEC_CYCLES   (MSEC_CYCLES),
    .MINUTE_CYCLES (MINUTE_CYCLES)
  ) u_tick (
    .clock    (clock),
    .rst_n    (rst_n),
    .gran_sel (idle_timer_granularity_select),
    .tick_r   (gran_tick)
  );

  // Idle timer: held at reload+1 while off, counts down on each tick
  // Expiry is one cycle wide, so each pass through zero records one event
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      idle_count_r    <= 9'h010;
      timer_expired_r <= 1'b0;
    end else if (idle_timer_granularity_select == `GRAN_OFF) begin
      idle_count_r    <= reload_plus_one;
      timer_expired_r <= 1'b0;
    end else if (idle_count_r == 9'h000) begin
      idle_count_r    <= reload_plus_one;
      timer_expired_r <= 1'b1;
    end else begin
      if (gran_tick)
        idle_count_r <= idle_count_r - 9'h001;
      timer_expired_r <= 1'b0;
    end
  end

  // Edge history; status is edge-set so a held source flags only once
  // Reset values match each pin's idle level, so no false edge follows reset
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ext_req_prev_r <= 1'b1;
      usb_prev_r     <= 1'b0;
      irq_prev_r     <= 5'h00;
    end else begin
      ext_req_prev_r <= external_mgmt_request_n;
      usb_prev_r     <= usb_legacy_req;
      irq_prev_r     <= irq_lines;
    end
  end

  always @* begin
    event_raw = 16'h0000;
    event_raw[`SRC_USB]    = usb_legacy_req & ~usb_prev_r;
    event_raw[`SRC_CMD_WR] = cmd_port_wr;
    event_raw[`SRC_EXT]    = ~external_mgmt_request_n & ext_req_prev_r;
    event_raw[`SRC_TIMER]  = timer_expired_r;
    event_raw[4:0]         = irq_lines & ~irq_prev_r;
  end

  // Software clears a status bit by writing zero to it
  always @* begin
    clear_mask = 16'h0000;
    if (wr_status_lo)
      clear_mask[7:0] = ~cfg_wdata;
    if (wr_status_hi)
      clear_mask[15:8] = ~cfg_wdata;
  end

  // Per-bit status; a new event in the clearing cycle wins over the clear
  generate
    for (g = 0; g < 16; g = g + 1) begin : g_status
      if (SRC_LIVE[g]) begin : g_live
        assign status_set[g]  = event_raw[g] & mgmt_irq_source_enable_r[g];
        assign status_keep[g] = mgmt_request_status_r[g] & ~clear_mask[g];
        assign status_nxt[g]  = status_keep[g] | status_set[g];
      end else begin : g_rsvd
        assign status_set[g]  = 1'b0;
        assign status_keep[g] = 1'b0;
        assign status_nxt[g]  = 1'b0;
      end
    end
  endgenerate

  // Power state does not enter either the status or the output path
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mgmt_request_status_r <= `RST_STATUS;
      mgmt_interrupt_out_n  <= 1'b1;
    end else begin
      mgmt_request_status_r <= status_nxt & `SRC_MASK;
      mgmt_interrupt_out_n  <= ~(gate_on & (|mgmt_request_status_r));
    end
  end

  // Stop-clock sequencer: plain assert, or scaled low/high alternation
  // Clearing the stop enable is seen one edge after the write lands
  always @* begin
    stop_state_nxt = stop_state_r;
    stop_count_nxt = stop_count_r;
    case (stop_state_r)
      ST_IDLE: begin
        if (stop_en && cmd_port_rd) begin
          stop_state_nxt = ST_LOW;
          stop_count_nxt = scaling_low_time;
        end
      end
      ST_LOW: begin
        if (!stop_en) begin
          stop_state_nxt = ST_IDLE;
        end else if (stop_clock_scaling_enable) begin
          if (stop_count_r == 8'h00) begin
            stop_state_nxt = ST_HIGH;
            stop_count_nxt = scaling_high_time;
          end else begin
            stop_count_nxt = stop_count_r - 8'h01;
          end
        end
      end
      ST_HIGH: begin
        if (!stop_en || !stop_clock_scaling_enable) begin
          stop_state_nxt = stop_en ? ST_LOW : ST_IDLE;
        end else if (stop_count_r == 8'h00) begin
          stop_state_nxt = ST_LOW;
          stop_count_nxt = scaling_low_time;
        end else begin
          stop_count_nxt = stop_count_r - 8'h01;
        end
      end
      default: begin
        stop_state_nxt = ST_IDLE;
        stop_count_nxt = 8'h00;
      end
    endcase
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stop_state_r     <= ST_IDLE;
      stop_count_r     <= 8'h00;
      stop_clock_out_n <= 1'b1;
    end else begin
      // Pin follows the next state, so it changes with the phase, not after it
      stop_state_r     <= stop_state_nxt;
      stop_count_r     <= stop_count_nxt;
      stop_clock_out_n <= (stop_state_nxt != ST_LOW);
    end
  end

endmodule // mgmt_interrupt_gate_enable

`default_nettype wire

// ==== core/mgmt_irq_map.vh ====
// Register offsets, field positions, reset values and timing counts for the
// management interrupt gate and source enable block.
// Assumes byte-wide configuration accesses on the documented config port.
`ifndef MGMT_IRQ_MAP_VH
`define MGMT_IRQ_MAP_VH

// Configuration byte offsets
`define OFS_CONTROL        8'ha0
`define OFS_ENABLE_LO      8'ha2
`define OFS_ENABLE_HI      8'ha3
`define OFS_TIMER_RELOAD   8'ha8
`define OFS_STATUS_LO      8'haa
`define OFS_STATUS_HI      8'hab

// Reset values
`define RST_CONTROL        8'h08
`define RST_ENABLE         16'h0000
`define RST_TIMER_RELOAD   8'h0f
`define RST_STATUS         16'h0000

// Control register fields
`define CTL_GATE           0
`define CTL_STOP_EN        1
`define CTL_SCALE_EN       2
`define CTL_GRAN_LSB       3
`define CTL_GRAN_MSB       4
`define CTL_MASK           8'h1f

// Granularity codes
`define GRAN_MINUTE        2'h0
`define GRAN_OFF           2'h1
`define GRAN_CLOCK         2'h2
`define GRAN_MSEC          2'h3

// Source enable and status bit positions
`define SRC_IRQ1           0
`define SRC_IRQ3           1
`define SRC_IRQ4           2
`define SRC_IRQ8           3
`define SRC_IRQ12          4
`define SRC_TIMER          5
`define SRC_EXT            6
`define SRC_CMD_WR         7
`define SRC_USB            8
`define SRC_MASK           16'h01ff

// Tick periods, fixed in PCI clocks as figured for a 33 MHz PCI clock
`define PCI_RATE_KHZ       33000
`define TICK_MSEC_TIME_MS  1
`define TICK_MINUTE_TIME_MS 60000
`define TICK_MSEC_CYCLES   (`TICK_MSEC_TIME_MS * `PCI_RATE_KHZ)
`define TICK_MINUTE_CYCLES (`TICK_MINUTE_TIME_MS * `PCI_RATE_KHZ)

`endif

// ==== sim/cpu_host.sv ====
// Host CPU model: counts entries of the management interrupt.
// Assumes a registered active-low request from the block.
`timescale 1ns/1ps
`default_nettype none
module cpu_host (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // From the block
  input  wire logic       irq_n,
  // Entries seen
  output var  logic [7:0] irq_seen
);
  logic irq_d;
  // Entries only, so a request held low counts once
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_d    <= 1'b1;
      irq_seen <= 8'h00;
    end else begin
      irq_d <= irq_n;
      if (irq_d && !irq_n) irq_seen <= irq_seen + 8'h01;
    end
  end
endmodule // cpu_host
`default_nettype wire

// ==== sim/mgmt_gate_assertions.sv ====
// Checker for the management interrupt gate block, bound to its top ports.
// Mirrors the control and low enable bytes from config writes.
`timescale 1ns/1ps
`default_nettype none
module mgmt_gate_chk (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst_n,
  // Config port
  input wire logic [7:0]  cfg_addr,
  input wire logic [7:0]  cfg_wdata,
  input wire logic        cfg_wr,
  // Sources
  input wire logic        cmd_port_wr,
  input wire logic        cmd_port_rd,
  input wire logic        external_mgmt_request_n,
  input wire logic [4:0]  irq_lines,
  input wire logic [7:0]  scaling_low_time,
  // Outputs
  input wire logic        mgmt_interrupt_out_n,
  input wire logic        stop_clock_out_n,
  input wire logic [15:0] mgmt_request_status_r
);
  logic [7:0] ctl_r;
  logic [7:0] en_r;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctl_r <= 8'h08;
      en_r  <= 8'h00;
    end else if (cfg_wr && cfg_addr == 8'ha0) begin
      ctl_r <= cfg_wdata;
    end else if (cfg_wr && cfg_addr == 8'ha2) begin
      en_r <= cfg_wdata;
    end
  end
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  a_gate_masks: assert property (!ctl_r[0] |=> mgmt_interrupt_out_n)
    else $error("interrupt low with gate clear");
  a_gate_pending: assert property (ctl_r[0] && |mgmt_request_status_r |=> !mgmt_interrupt_out_n)
    else $error("pending status not signalled");
  a_irq_record: assert property ($rose(irq_lines[0]) && en_r[0] |=> mgmt_request_status_r[0])
    else $error("request line not recorded");
  a_src_off: assert property ($rose(irq_lines[4]) && !en_r[4] && !mgmt_request_status_r[4]
    |=> !mgmt_request_status_r[4])
    else $error("disabled line recorded");
  a_ext_record: assert property ($fell(external_mgmt_request_n) && en_r[6] |=> mgmt_request_status_r[6])
    else $error("external request not recorded");
  a_cmd_record: assert property (cmd_port_wr && en_r[7] |=> mgmt_request_status_r[7])
    else $error("command write not recorded");
  a_stop_start: assert property (cmd_port_rd && ctl_r[2:1] == 2'b01 && stop_clock_out_n
    |=> !stop_clock_out_n)
    else $error("stop clock not started");
  a_stop_release: assert property (cfg_wr && cfg_addr == 8'ha0 && !cfg_wdata[1] |-> ##2 stop_clock_out_n)
    else $error("stop clock not released");
  a_stop_scaled: assert property ($fell(stop_clock_out_n) && ctl_r[2] && scaling_low_time == 8'h02
    |-> !stop_clock_out_n [*3] ##1 stop_clock_out_n)
    else $error("scaled low phase wrong");
  c_irq: cover property (!mgmt_interrupt_out_n);
  c_scaled: cover property ($fell(stop_clock_out_n) && ctl_r[2]);
  c_timer: cover property ($rose(mgmt_request_status_r[5]));
endmodule // mgmt_gate_chk
bind mgmt_interrupt_gate_enable mgmt_gate_chk chk_u (.clock, .rst_n, .cfg_addr, .cfg_wdata,
  .cfg_wr, .cmd_port_wr, .cmd_port_rd, .external_mgmt_request_n, .irq_lines,
  .scaling_low_time, .mgmt_interrupt_out_n, .stop_clock_out_n, .mgmt_request_status_r);
`default_nettype wire

// ==== sim/mgmt_interrupt_gate_enable_tb.sv ====
// Testbench for the management interrupt gate block.
// Drives config port and sources; a host model counts interrupt entries.
`timescale 1ns/1ps
`default_nettype none
module mgmt_interrupt_gate_enable_tb;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  cfg_addr = 8'h00;
  logic [7:0]  cfg_wdata = 8'h00;
  logic        cfg_wr = 1'b0;
  logic        cfg_rd = 1'b0;
  logic        cmd_wr = 1'b0;
  logic        cmd_rd = 1'b0;
  logic        usb = 1'b0;
  logic        ext_n = 1'b1;
  logic [4:0]  irq = 5'h00;
  logic [7:0]  rdata;
  logic        irq_n;
  logic        stop_n;
  logic [15:0] status;
  logic [7:0]  irq_seen;
  logic        rd_q = 1'b0;
  logic [7:0]  exp_q[$];
  logic [7:0]  r;
  logic [7:0]  tm[3] = '{8'h10, 8'h18, 8'h00};
  integer      lo[3] = '{3, 12, 30};
  integer      hi[3] = '{12, 40, 90};
  integer      errors = 0;
  integer      checked = 0;
  integer      cycles = 0;
  integer      seed = 32'hf089;
  integer      k;
  integer      n;
  always #5 clock = ~clock;
  mgmt_interrupt_gate_enable #(.MSEC_CYCLES(32'd4), .MINUTE_CYCLES(32'd10)) dut_u (
    .clock(clock), .rst_n(rst_n), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rdata_r(rdata), .cmd_port_wr(cmd_wr),
    .cmd_port_rd(cmd_rd), .usb_legacy_req(usb), .external_mgmt_request_n(ext_n),
    .irq_lines(irq), .scaling_high_time(8'h01), .scaling_low_time(8'h02),
    .mgmt_interrupt_out_n(irq_n), .stop_clock_out_n(stop_n), .mgmt_request_status_r(status));
  cpu_host host_u (.clock(clock), .rst_n(rst_n), .irq_n(irq_n), .irq_seen(irq_seen));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    cfg_addr <= a;
    cfg_wdata <= d;
    cfg_wr <= 1'b1;
    @(posedge clock);
    cfg_wr <= 1'b0;
  endtask
  // Read result is noted here and compared by the monitor below
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clock);
    cfg_addr <= a;
    cfg_rd <= 1'b1;
    @(posedge clock);
    cfg_rd <= 1'b0;
    @(negedge clock);
  endtask
  always @(posedge clock) rd_q <= cfg_rd;
  always @(negedge clock) if (rd_q) check(rdata, exp_q.pop_front());
  task automatic fire(input integer b);
    @(posedge clock);
    if (b < 5) irq[b] <= 1'b1;
    else if (b == 6) ext_n <= 1'b0;
    else if (b == 7) cmd_wr <= 1'b1;
    else usb <= 1'b1;
    @(posedge clock);
    cmd_wr <= 1'b0;
    repeat (2) @(posedge clock);
    irq <= 5'h00;
    ext_n <= 1'b1;
    usb <= 1'b0;
    @(negedge clock);
  endtask
  task automatic pulse_rd();
    @(posedge clock);
    cmd_rd <= 1'b1;
    @(posedge clock);
    cmd_rd <= 1'b0;
    @(negedge clock);
  endtask
  task automatic wait_set(input integer lo_c, input integer hi_c);
    n = 0;
    while (status[5] !== 1'b1 && n < hi_c) begin
      @(posedge clock);
      n = n + 1;
    end
    check(n >= lo_c && n < hi_c, 1'b1);
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles > 20000) begin
      errors = errors + 1;
      finish_test();
    end
  end
  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    rd(8'ha0, 8'h08);
    rd(8'ha2, 8'h00);
    rd(8'ha3, 8'h00);
    rd(8'ha8, 8'h0f);
    rd(8'h40, 8'h00);
    wr(8'ha0, 8'he0);
    rd(8'ha0, 8'h00);
    wr(8'ha0, 8'h08);
    $display("test registers done");
    // Line 4 stays disabled so an edge on a masked line is always seen
    r = 8'($random(seed)) & 8'hef;
    wr(8'ha2, r);
    fire(0);
    @(posedge clock);
    irq <= 5'h1f;
    repeat (3) @(posedge clock);
    irq <= 5'h00;
    rd(8'haa, r & 8'h1f);
    check(irq_n, 1'b1);
    wr(8'haa, 8'h00);
    $display("test random enables done");
    wr(8'ha2, 8'hdf);
    wr(8'ha3, 8'h01);
    for (k = 0; k < 9; k++) begin
      if (k != 5) begin
        fire(k);
        check(status, 16'h0001 << k);
        check(irq_n, 1'b1);
        wr(8'ha0, 8'h09);
        repeat (2) @(negedge clock);
        check(irq_n, 1'b0);
        wr(8'haa, 8'h00);
        wr(8'hab, 8'h00);
        wr(8'ha0, 8'h08);
        @(negedge clock);
        check(irq_n, 1'b1);
      end
    end
    check(irq_seen, 8'd8);
    $display("test sources done");
    wr(8'ha2, 8'h20);
    wr(8'ha8, 8'h03);
    rd(8'ha8, 8'h03);
    repeat (40) @(posedge clock);
    check(status[5], 1'b0);
    for (k = 0; k < 3; k++) begin
      wr(8'ha0, tm[k]);
      wait_set(lo[k], hi[k]);
      wr(8'ha0, 8'h08);
      wr(8'haa, 8'h00);
    end
    $display("test idle timer done");
    pulse_rd();
    check(stop_n, 1'b1);
    for (k = 0; k < 2; k++) begin
      wr(8'ha0, k ? 8'h0e : 8'h0a);
      pulse_rd();
      check(stop_n, 1'b0);
      n = 0;
      repeat (12) @(negedge clock) n = n + stop_n;
      check(n, k ? 16'd4 : 16'd0);
      wr(8'ha0, 8'h08);
      repeat (2) @(negedge clock);
      check(stop_n, 1'b1);
    end
    $display("test stop clock done");
    finish_test();
  end
endmodule // mgmt_interrupt_gate_enable_tb
`default_nettype wire
